// ---- pkg/gpio_fall_pkg.sv ----
// constants, register map and carrier types for the falling-edge / high-mask block
package gpio_fall_pkg;
    localparam int PIN_COUNT = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] ADDR_FALL_FLAGS = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_HIGH_MASK = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_RISE_FLAGS = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PIN_ENABLE = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIR = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h8;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
    // status bit positions of the sticky interrupt register
    localparam int STAT_FALL = 0;
    localparam int STAT_RISE = 1;
    localparam int STAT_EVENT = 2;
    localparam int STAT_W = 3;
    // mode select: edge flags or latched level gated by the high mask
    localparam logic MODE_EDGE = 1'b0;
    localparam logic MODE_LEVEL = 1'b1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;
endpackage

// ---- rtl/gpio_fall_detect_high_mask.sv ----
// falling-edge flags, high-side mask and pin-qualified event generation
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps

// How it works
// - a high-to-low transition on a pin sets its falling-edge flag.
// - falling flags sit in bits 15..0; detection only on enabled input pins.
// - output pins keep their falling-edge flag unchanged.
// - writing one clears a flag bit; writing zero leaves it alone.
// - bits 31..16 of flag and mask registers read zero, ignore writes.
// - flags and mask reset to zero and are software readable and writable.
// - a zero mask bit blocks that pin from event_out and the event status bit; fall and rise status still set.
// - a one mask bit allows events from rising flag or latched value.
// - the selected interrupt mode decides if an allowed event is produced.
// - mask bits sit in bits 15..0 and act only on enabled input pins.
// - a sticky rising-edge flag per pin is set on low-to-high transitions.
// - an input pin's level is latched into its value bit.
// - direction zero means input, one output, only when the pin is enabled.
module gpio_fall_detect_high_mask
    import gpio_fall_pkg::*;
#(
    parameter int PINS = PIN_COUNT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [gpio_fall_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_fall_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_fall_pkg::DATA_W-1:0] reg_rdata,
    // pins
    input wire logic [PINS-1:0] general_pin,
    // outputs
    output logic event_out,
    output logic irq
);
    import gpio_fall_pkg::*;

    bus_req_t req;
    logic [PINS-1:0] sync1, sync2, prev;
    logic [PINS-1:0] fall_flag_bits, next_fall_flag_bits;
    logic [PINS-1:0] rise_flag_bits, next_rise_flag_bits;
    logic [PINS-1:0] high_mask_bits, next_high_mask_bits;
    logic [PINS-1:0] pin_level_bits, next_pin_level_bits;
    logic [PINS-1:0] pin_enable_bits, next_pin_enable_bits;
    logic [PINS-1:0] pin_direction_bits, next_pin_direction_bits;
    logic [STAT_W-1:0] irq_status, next_irq_status;
    logic [STAT_W-1:0] irq_mask, next_irq_mask;
    logic mode, next_mode;
    logic event_out_r, next_event_out;
    logic irq_r, next_irq;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic [PINS-1:0] is_input, fell, rose, wr_fall_clr, wr_rise_clr;
    logic any_fall, any_rise, ev;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // two-stage synchroniser, then a third stage as the previous sample
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end
        else
        begin
            sync1 <= general_pin;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // per-pin edge detection and write-one-to-clear strobes
    genvar g;
    generate
        for (g = 0; g < PINS; g++)
        begin : g_pin
            // direction only counts while the pin is enabled
            assign is_input[g] = pin_enable_bits[g]
                && !pin_direction_bits[g];
            assign fell[g] = is_input[g] && prev[g]
                && !sync2[g];
            assign rose[g] = is_input[g] && !prev[g]
                && sync2[g];
            assign wr_fall_clr[g] = req.wr && req.addr == ADDR_FALL_FLAGS
                && req.wdata[g];
            assign wr_rise_clr[g] = req.wr && req.addr == ADDR_RISE_FLAGS
                && req.wdata[g];
        end
    endgenerate

    assign any_fall = |fell;
    assign any_rise = |rose;

    always_comb
    begin
        next_fall_flag_bits = fall_flag_bits;
        next_rise_flag_bits = rise_flag_bits;
        next_high_mask_bits = high_mask_bits;
        next_pin_level_bits = pin_level_bits;
        next_pin_enable_bits = pin_enable_bits;
        next_pin_direction_bits = pin_direction_bits;
        next_irq_status = irq_status;
        next_irq_mask = irq_mask;
        next_mode = mode;
        next_rdata = READ_ZERO;
        ev = 1'b0;

        // clear first, then set so a same-cycle edge wins
        next_fall_flag_bits = (fall_flag_bits & ~wr_fall_clr)
            | fell;
        next_rise_flag_bits = (rise_flag_bits & ~wr_rise_clr)
            | rose;

        // output pins keep the value software last wrote
        next_pin_level_bits = (pin_level_bits & ~is_input)
            | (sync2 & is_input);

        if (req.wr)
        begin
            case (req.addr)
                ADDR_HIGH_MASK:
                    next_high_mask_bits = req.wdata[PINS-1:0];
                ADDR_PIN_LEVEL:
                    next_pin_level_bits = (req.wdata[PINS-1:0] & ~is_input)
                        | (sync2 & is_input);
                ADDR_PIN_ENABLE:
                    next_pin_enable_bits = req.wdata[PINS-1:0];
                ADDR_PIN_DIR:
                    next_pin_direction_bits = req.wdata[PINS-1:0];
                ADDR_IRQ_MASK:
                    next_irq_mask = req.wdata[STAT_W-1:0];
                ADDR_MODE:
                    next_mode = req.wdata[0];
                default:
                    next_mode = mode;
            endcase
        end

        // mask gates each pin; mode picks edge or level source
        case (mode)
            MODE_EDGE:
                ev = |(high_mask_bits & is_input
                    & rise_flag_bits);
            MODE_LEVEL:
                ev = |(high_mask_bits & is_input
                    & pin_level_bits);
            default:
                ev = 1'b0;
        endcase

        // sticky status: write-one-to-clear, new event wins
        if (req.wr && req.addr == ADDR_IRQ_STATUS)
            next_irq_status = irq_status & ~req.wdata[STAT_W-1:0];
        if (any_fall)
            next_irq_status[STAT_FALL] = 1'b1;
        if (any_rise)
            next_irq_status[STAT_RISE] = 1'b1;
        if (ev)
            next_irq_status[STAT_EVENT] = 1'b1;

        if (req.rd)
        begin
            case (req.addr)
                ADDR_FALL_FLAGS:
                    next_rdata = {{(DATA_W-PINS){1'b0}},
                        fall_flag_bits};
                ADDR_HIGH_MASK:
                    next_rdata = {{(DATA_W-PINS){1'b0}}, high_mask_bits};
                ADDR_RISE_FLAGS:
                    next_rdata = {{(DATA_W-PINS){1'b0}}, rise_flag_bits};
                ADDR_PIN_LEVEL:
                    next_rdata = {{(DATA_W-PINS){1'b0}}, pin_level_bits};
                ADDR_PIN_ENABLE:
                    next_rdata = {{(DATA_W-PINS){1'b0}}, pin_enable_bits};
                ADDR_PIN_DIR:
                    next_rdata = {{(DATA_W-PINS){1'b0}}, pin_direction_bits};
                ADDR_IRQ_STATUS:
                    next_rdata = {{(DATA_W-STAT_W){1'b0}}, irq_status};
                ADDR_IRQ_MASK:
                    next_rdata = {{(DATA_W-STAT_W){1'b0}}, irq_mask};
                ADDR_MODE:
                    next_rdata = {{(DATA_W-1){1'b0}}, mode};
                default:
                    next_rdata = READ_ZERO;
            endcase
        end

        next_event_out = ev;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fall_flag_bits <= FLAGS_RESET;
            rise_flag_bits <= FLAGS_RESET;
            high_mask_bits <= MASK_RESET;
            pin_level_bits <= '0;
            pin_enable_bits <= '0;
            pin_direction_bits <= '0;
            irq_status <= '0;
            irq_mask <= '0;
            mode <= MODE_EDGE;
            rdata <= READ_ZERO;
            event_out_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            fall_flag_bits <= next_fall_flag_bits;
            rise_flag_bits <= next_rise_flag_bits;
            high_mask_bits <= next_high_mask_bits;
            pin_level_bits <= next_pin_level_bits;
            pin_enable_bits <= next_pin_enable_bits;
            pin_direction_bits <= next_pin_direction_bits;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            mode <= next_mode;
            rdata <= next_rdata;
            event_out_r <= next_event_out;
            irq_r <= next_irq;
        end
    end

    assign reg_rdata = rdata;
    assign event_out = event_out_r;
    assign irq = irq_r;
endmodule

// ---- tb/gpio_fall_assertions.sv ----
// property checker for the falling-edge and high-mask block
`timescale 1ns/10ps
module gpio_fall_assertions
    import gpio_fall_pkg::*;
#(
    parameter int PINS = PIN_COUNT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [gpio_fall_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_fall_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [gpio_fall_pkg::DATA_W-1:0] reg_rdata,
    // pins and outputs
    input wire logic [PINS-1:0] general_pin,
    input wire logic event_out,
    input wire logic irq
);
    logic [15:0] mask, en, dir, pin_q, next_mask, next_en, next_dir;
    logic [2:0] imask, quiet, next_imask, next_quiet;
    // shadows of the configuration, taken from the writes seen on the port
    always_comb
    begin
        next_mask = mask;
        next_en = en;
        next_dir = dir;
        next_imask = imask;
        if (reg_wr && reg_addr == ADDR_HIGH_MASK) next_mask = reg_wdata[15:0];
        if (reg_wr && reg_addr == ADDR_PIN_ENABLE) next_en = reg_wdata[15:0];
        if (reg_wr && reg_addr == ADDR_PIN_DIR) next_dir = reg_wdata[15:0];
        if (reg_wr && reg_addr == ADDR_IRQ_MASK) next_imask = reg_wdata[2:0];
        next_quiet = (general_pin != pin_q) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst) {mask, en, dir, imask, quiet, pin_q} <= '0;
        else {mask, en, dir, imask, quiet, pin_q} <=
            {next_mask, next_en, next_dir, next_imask, next_quiet, general_pin};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence clear_all;
        reg_wr && reg_addr == ADDR_FALL_FLAGS && reg_wdata[15:0] == 16'hffff
            && quiet > 3'h4;
    endsequence
    sequence read_flags;
        reg_rd && reg_addr == ADDR_FALL_FLAGS;
    endsequence
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == READ_ZERO)
        else $error("read data not zero outside a read");
    a_flag_upper_zero: assert property (read_flags |=> reg_rdata[31:16] == 16'h0)
        else $error("flag upper half not zero");
    a_mask_readback: assert property (reg_rd && reg_addr == ADDR_HIGH_MASK
        |=> reg_rdata == {16'h0, mask}) else $error("mask readback wrong");
    a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_MODE
        |=> reg_rdata == READ_ZERO) else $error("unmapped read not zero");
    a_mask_blocks_event: assert property (mask == 16'h0 && $past(mask) == 16'h0
        |-> !event_out) else $error("event with mask clear");
    a_irq_masked_off: assert property (imask == 3'h0 && $past(imask) == 3'h0
        |-> !irq) else $error("interrupt while fully masked");
    a_fall_raises_irq: assert property ($fell(general_pin[0]) && en[0] && !dir[0]
        && imask[STAT_FALL] |-> ##[3:5] irq) else $error("fall gave no interrupt");
    a_clear_then_empty: assert property (clear_all ##2 read_flags
        |=> reg_rdata == READ_ZERO) else $error("flags not cleared");
endmodule
bind gpio_fall_detect_high_mask gpio_fall_assertions #(.PINS(PINS)) u_chk (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .general_pin(general_pin), .event_out(event_out), .irq(irq));

// ---- tb/pin_source.sv ----
// behavioural source of the external pin levels
`timescale 1ns/10ps
module pin_source
(
    // clock
    input wire logic clk,
    // pins
    output logic [15:0] general_pin
);
    initial general_pin = 16'hffff;
    // a level stands at least two cycles so the synchroniser cannot miss it
    task automatic set(input logic [15:0] v);
        @(posedge clk);
        general_pin <= v;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- tb/tb.sv ----
// register-level tests of the falling-edge and high-mask block
`timescale 1ns/10ps
module tb;
    import gpio_fall_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, d;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic event_out, irq;
    logic [15:0] general_pin;
    int miscompares = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    pin_source u_pins (.clk(clk), .general_pin(general_pin));
    gpio_fall_detect_high_mask u_dut (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .general_pin(general_pin),
        .event_out(event_out), .irq(irq));
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, g);
        chk_word(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        chk_word("rdata", e, d);
    endtask
    // outputs are looked at one step after the edge so its updates have landed
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #100us;
        miscompares++;
        complete_run;
    end
    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(ADDR_FALL_FLAGS, 32'h0);
        rchk(ADDR_HIGH_MASK, 32'h0);
        wr(ADDR_HIGH_MASK, 32'hffff_a5c3);
        rchk(ADDR_HIGH_MASK, 32'h0000_a5c3);
        rchk(4'hf, 32'h0);
        $display("register test done");
        wr(ADDR_PIN_ENABLE, 32'h0000_ffff);
        wr(ADDR_IRQ_MASK, 32'h1);
        u_pins.set(16'h5a5a);
        settle(3);
        rchk(ADDR_FALL_FLAGS, 32'h0000_a5a5);
        chk_bit("irq", 1'b1, irq);
        wr(ADDR_FALL_FLAGS, 32'hffff_0005);
        rchk(ADDR_FALL_FLAGS, 32'h0000_a5a0);
        wr(ADDR_PIN_DIR, 32'h0000_ff00);
        u_pins.set(16'h0000);
        settle(3);
        rchk(ADDR_FALL_FLAGS, 32'h0000_a5fa);
        wr(ADDR_FALL_FLAGS, 32'h0000_ffff);
        rchk(ADDR_FALL_FLAGS, 32'h0);
        $display("edge flag test done");
        wr(ADDR_PIN_DIR, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_IRQ_STATUS, 32'h7);
        u_pins.set(16'hffff);
        rchk(ADDR_RISE_FLAGS, 32'h0000_ffff);
        u_pins.set(16'h0000);
        settle(3);
        chk_bit("irq", 1'b0, irq);
        wr(ADDR_IRQ_MASK, 32'h1);
        settle(2);
        chk_bit("irq", 1'b1, irq);
        wr(ADDR_IRQ_STATUS, 32'h7);
        wr(ADDR_IRQ_MASK, 32'h0);
        settle(2);
        chk_bit("irq", 1'b0, irq);
        $display("interrupt test done");
        wr(ADDR_HIGH_MASK, 32'h1);
        wr(ADDR_MODE, {31'h0, MODE_EDGE});
        settle(2);
        chk_bit("event_out", 1'b1, event_out);
        wr(ADDR_MODE, {31'h0, MODE_LEVEL});
        settle(2);
        chk_bit("event_out", 1'b0, event_out);
        u_pins.set(16'h0001);
        settle(3);
        chk_bit("event_out", 1'b1, event_out);
        rchk(ADDR_PIN_LEVEL, 32'h0000_0001);
        wr(ADDR_HIGH_MASK, 32'h0);
        settle(2);
        chk_bit("event_out", 1'b0, event_out);
        $display("event test done");
        complete_run;
    end
endmodule
